// ===== hw/bsd_top.sv
// Board status registers on the processor bus plus card buffer and serial
// transceiver enables. Assumes a synchronous bus strobe from logic on CLK.
//
// Overview of operation
// - Four status registers at word steps, repeating every sixteen bytes.
// - Register contents travel only on the upper sixteen data lines.
// - Card enabled: address and strobe buffers always drive toward card.
// - Card enabled: data buffers on only with a lane enable; direction from read.
// - Card enabled: card status lines pass toward the processor.
// - Card disabled: address, strobe, data, status buffers all tri-stated.
// - Serial transceiver shut down unless enabled; active when enabled.
// - Card indicator lit exactly while card buffers are enabled.
// - Memory decode ignores privilege, instruction/data and DMA origin.
// - Flash answers its select only when the flash enable bit is set.
`timescale 1ns/10ps
module bsd_top
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // Processor bus
  input  wire logic        BUS_CS,
  input  wire logic        BUS_WR,
  input  wire logic [31:0] BUS_ADDR,
  input  wire logic [31:0] BUS_WDATA,
  input  wire logic [2:0]  BUS_ACCESS_TYPE,
  output logic      [31:0] BUS_RDATA,
  output logic      [31:0] BUS_RDATA_OE,
  // Memory selects
  output logic             FLASH_SEL,
  // Card channel
  input  wire logic        CARD_LANE_ENABLE_LOW_N,
  input  wire logic        CARD_LANE_ENABLE_HIGH_N,
  input  wire logic        CARD_READ,
  output logic             CARD_ADDR_BUF_OE,
  output logic             CARD_DATA_BUF_OE,
  output logic             CARD_DATA_TO_CARD,
  output logic             CARD_STATUS_BUF_OE,
  output logic             CARD_LED,
  // Serial channel one transceiver
  output logic             SERIAL_SHUTDOWN_N,
  // Board switches shown in register zero
  input  wire logic [3:0]  SW_OPTIONS
);
  import bsd_pkg::*;

  // ==========================================================================
  // Decode
  logic              reg_hit;
  logic [1:0]        reg_idx;
  logic [BSD_HALF_W-1:0] regs_q [BSD_NREGS];
  logic [3:0]        sw_meta_q;
  logic [3:0]        sw_sync_q;
  logic [1:0]        lane_meta_q;
  logic [1:0]        lane_sync_q;
  logic              dir_meta_q;
  logic              dir_sync_q;
  logic              card_on;
  logic              flash_on;
  logic              serial_on;

  // Window test shared by the register and flash decodes. The access type tag never
  // enters it, so user, supervisor, fetch, data and DMA cycles are all served alike.
  function automatic logic bsd_in_window(input logic [31:0] addr,
                                         input logic [31:0] base,
                                         input logic [31:0] mask);
    return (addr & mask) == base;
  endfunction : bsd_in_window

  // Places a register half word on the upper data lines; the lower lines stay zero.
  function automatic logic [31:0] bsd_upper_word(input logic [BSD_HALF_W-1:0] half);
    return {half, 16'h0000};
  endfunction : bsd_upper_word

  // Control bit lookup in register one, shared by every board control below.
  function automatic logic bsd_ctrl_bit(input logic [BSD_HALF_W-1:0] ctrl,
                                        input int                    pos);
    return ctrl[pos];
  endfunction : bsd_ctrl_bit

  assign reg_hit = BUS_CS && bsd_in_window(BUS_ADDR, BSD_REG_BASE, BSD_REG_MASK);
  // Only two index bits take part, so the set of four repeats every sixteen bytes.
  assign reg_idx = BUS_ADDR[BSD_IDX_MSB:BSD_IDX_LSB];

  // ==========================================================================
  // Registers: only the upper half of the write data is used.
  // Register zero is never written; it only mirrors the switches.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      for (int i = 0; i < BSD_NREGS; i++)
        regs_q[i] <= BSD_RST_CTRL;
    end
    else if (reg_hit && BUS_WR && reg_idx != BSD_IDX_CTRL0)
    begin
      regs_q[reg_idx] <= BUS_WDATA[31:BSD_DATA_LSB];
    end
  end

  // Switches, lane enables and the transfer direction come from pins and pass two
  // flip-flops first. Lane enables reset to their idle high level, so no lane request
  // is seen while the pins settle; the direction resets toward the processor.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      sw_meta_q   <= 4'h0;
      sw_sync_q   <= 4'h0;
      lane_meta_q <= 2'h3;
      lane_sync_q <= 2'h3;
      dir_meta_q  <= 1'b1;
      dir_sync_q  <= 1'b1;
    end
    else
    begin
      sw_meta_q   <= SW_OPTIONS;
      sw_sync_q   <= sw_meta_q;
      lane_meta_q <= {CARD_LANE_ENABLE_HIGH_N, CARD_LANE_ENABLE_LOW_N};
      lane_sync_q <= lane_meta_q;
      dir_meta_q  <= CARD_READ;
      dir_sync_q  <= dir_meta_q;
    end
  end

  // ==========================================================================
  // Read path: register zero is read-only and shows the switches.
  // Data is registered, so it stands for the single cycle after the read.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      BUS_RDATA    <= 32'h0000_0000;
      BUS_RDATA_OE <= 32'h0000_0000;
    end
    else if (reg_hit && !BUS_WR)
    begin
      if (reg_idx == BSD_IDX_CTRL0)
        BUS_RDATA <= bsd_upper_word({12'h000, sw_sync_q});
      else
        BUS_RDATA <= bsd_upper_word(regs_q[reg_idx]);
      BUS_RDATA_OE <= 32'hFFFF_0000;
    end
    else
    begin
      BUS_RDATA    <= 32'h0000_0000;
      BUS_RDATA_OE <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Board controls
  // All enables sit in register one and clear at reset, which frees the channel pins.
  assign card_on   = bsd_ctrl_bit(regs_q[BSD_IDX_CTRL1], BSD_BIT_CARD);
  assign flash_on  = bsd_ctrl_bit(regs_q[BSD_IDX_CTRL1], BSD_BIT_FLASH);
  assign serial_on = bsd_ctrl_bit(regs_q[BSD_IDX_CTRL1], BSD_BIT_SERIAL);

  // With the flash disabled its select stays low and is left to an off-board device.
  assign FLASH_SEL = BUS_CS && flash_on
                     && bsd_in_window(BUS_ADDR, BSD_FLASH_BASE, BSD_FLASH_MASK);

  assign CARD_ADDR_BUF_OE   = card_on;
  assign CARD_STATUS_BUF_OE = card_on;
  assign CARD_DATA_BUF_OE   = card_on && (lane_sync_q != 2'h3);
  // The direction pin is synchronised like the lane enables, so both settle together.
  assign CARD_DATA_TO_CARD  = !dir_sync_q;
  assign CARD_LED           = card_on;
  assign SERIAL_SHUTDOWN_N  = serial_on;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  read_lanes_a: assert property (reg_hit && !BUS_WR |=> BUS_RDATA_OE == 32'hFFFF_0000)
    else $error("Register read drove wrong lanes.");
  low_half_a: assert property (BUS_RDATA[15:0] == 16'h0000)
    else $error("Lower data lines carry data.");
  alias_write_a: assert property (
      reg_hit && BUS_WR && reg_idx == BSD_IDX_CTRL1
      |=> card_on == $past(BUS_WDATA[BSD_DATA_LSB+BSD_BIT_CARD]))
    else $error("Aliased write missed register one.");
  card_off_a: assert property (
      !card_on |-> !CARD_ADDR_BUF_OE && !CARD_DATA_BUF_OE && !CARD_STATUS_BUF_OE)
    else $error("Buffers driven with card off.");
  card_led_a: assert property (CARD_LED == CARD_ADDR_BUF_OE)
    else $error("Card indicator mismatch.");
  data_lane_a: assert property (card_on && lane_sync_q == 2'h3 |-> !CARD_DATA_BUF_OE)
    else $error("Data buffer on without lane enable.");
  status_on_a: assert property (card_on |-> CARD_STATUS_BUF_OE && CARD_ADDR_BUF_OE)
    else $error("Card buffers off while enabled.");
  flash_gate_a: assert property (FLASH_SEL |-> regs_q[BSD_IDX_CTRL1][BSD_BIT_FLASH])
    else $error("Flash selected while disabled.");
  serial_a: assert property (
      reg_hit && BUS_WR && reg_idx == BSD_IDX_CTRL1
      |=> SERIAL_SHUTDOWN_N == $past(BUS_WDATA[BSD_DATA_LSB+BSD_BIT_SERIAL]))
    else $error("Serial shutdown not following write.");
  // Read contents are compared one cycle after the access, in the cycle in which
  // the host samples them.
  read_data_a: assert property (
      reg_hit && !BUS_WR && reg_idx != BSD_IDX_CTRL0
      |=> BUS_RDATA == bsd_upper_word($past(regs_q[reg_idx])))
    else $error("Register read returned wrong contents.");
  zero_read_a: assert property (
      reg_hit && !BUS_WR && reg_idx == BSD_IDX_CTRL0
      |=> BUS_RDATA == bsd_upper_word({12'h000, $past(sw_sync_q)}))
    else $error("Switch register read returned wrong contents.");
  idle_quiet_a: assert property (
      !(reg_hit && !BUS_WR) |=> BUS_RDATA_OE == 32'h0000_0000)
    else $error("Data lines driven outside a register read.");
  // Direction needs three quiet cycles: one for the pin edge, two for the synchroniser.
  dir_follow_a: assert property (
      $stable(CARD_READ) [*3] |-> CARD_DATA_TO_CARD == !CARD_READ)
    else $error("Data buffer direction does not follow the transfer.");

  // Covers for the main traffic: card reads and writes, aliased reads, flash and DMA access.
  card_read_c: cover property (card_on && CARD_DATA_BUF_OE && CARD_READ);
  card_write_c: cover property (card_on && CARD_DATA_BUF_OE && !CARD_READ);
  reg_read_c: cover property (reg_hit && !BUS_WR && BUS_ADDR[4]);
  flash_c: cover property (FLASH_SEL);
  any_access_c: cover property (FLASH_SEL && BUS_ACCESS_TYPE == 3'h7);
endmodule : bsd_top

// ===== hw/bsd_pkg.sv
// Constants for the board status decode and card buffer control block.
// Assumes a 32-bit processor bus with byte addresses and a 250 MHz clock.
package bsd_pkg;
  // ==========================================================================
  // Address decode
  localparam logic [31:0] BSD_REG_BASE    = 32'h0210_0000;
  localparam logic [31:0] BSD_REG_MASK    = 32'hFFFF_C000;
  localparam logic [31:0] BSD_FLASH_BASE  = 32'h0280_0000;
  localparam logic [31:0] BSD_FLASH_MASK  = 32'hFF80_0000;
  localparam int          BSD_IDX_LSB     = 2;
  localparam int          BSD_IDX_MSB     = 3;
  localparam int          BSD_NREGS       = 4;
  localparam int          BSD_HALF_W      = 16;
  localparam int          BSD_DATA_LSB    = 16;
  // ==========================================================================
  // Register indices and bit positions
  localparam logic [1:0]  BSD_IDX_CTRL0   = 2'h0;
  localparam logic [1:0]  BSD_IDX_CTRL1   = 2'h1;
  localparam int          BSD_BIT_FLASH   = 15;
  localparam int          BSD_BIT_CARD    = 14;
  localparam int          BSD_BIT_SERIAL  = 13;
  // ==========================================================================
  // Reset values: everything off so the channel pins are free.
  localparam logic [15:0] BSD_RST_CTRL    = 16'h0000;
endpackage : bsd_pkg

// ===== verification/bsd_card_model.sv
// Card socket model: drives the lane enables and transfer direction.
// Assumes the bench commands it; pins move only on the clock edge.
`timescale 1ns/10ps
module bsd_card_model
(
  // Clock
  input  wire logic       clk,
  // Commands from the bench
  input  wire logic [1:0] lane_n_cmd,
  input  wire logic       rd_cmd,
  // Socket pins
  output logic            lane_low_n,
  output logic            lane_high_n,
  output logic            card_rd
);
  // ==========================================================================
  // Socket pins
  // A real socket changes lines with the bus clock, so the model never moves them mid-cycle.
  always_ff @(posedge clk)
  begin
    {lane_high_n, lane_low_n} <= lane_n_cmd;
    card_rd                   <= rd_cmd;
  end
endmodule : bsd_card_model

// ===== verification/testbench.sv
// Self-checking bench for the board status decode and card buffer block.
// Assumes bsd_pkg and the card socket model are compiled first.
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import bsd_pkg::*;
  typedef struct packed {logic wr; logic [31:0] a, d, rd, oe;} bsd_row_t;
  logic        clk, rstn, cs, wr, rd_cmd;
  logic [31:0] addr, wdata, rdata, oe;
  logic [2:0]  acc;
  logic [1:0]  lane_cmd;
  logic        lo_n, hi_n, crd, flash, a_oe, d_oe, to_card, s_oe, led, ser_n;
  int          num_errors = 0;
  int          checks = 0;
  bsd_row_t    rows [10] = '{
    '{1, 32'h0210_0014, 32'hC000_FFFF, 0, 0}, '{0, 32'h0210_0004, 0, 32'hC000_0000, 32'hFFFF_0000},
    '{1, 32'h0210_0008, 32'h1234_5678, 0, 0}, '{0, 32'h0210_3FF8, 0, 32'h1234_0000, 32'hFFFF_0000},
    '{1, 32'h0210_0000, 32'hFFFF_FFFF, 0, 0}, '{0, 32'h0210_0010, 0, 32'h000A_0000, 32'hFFFF_0000},
    '{1, 32'h0210_4000, 32'hFFFF_0000, 0, 0}, '{0, 32'h0210_4000, 0, 32'h0000_0000, 32'h0000_0000},
    '{1, 32'h0210_000C, 32'hBEEF_0001, 0, 0},
    '{0, 32'h0210_002C, 0, 32'hBEEF_0000, 32'hFFFF_0000}};
  bsd_card_model CARD (.clk(clk), .lane_n_cmd(lane_cmd), .rd_cmd(rd_cmd), .lane_low_n(lo_n),
    .lane_high_n(hi_n), .card_rd(crd));
  bsd_top DUT (.CLK(clk), .RSTN(rstn), .BUS_CS(cs), .BUS_WR(wr), .BUS_ADDR(addr),
    .BUS_WDATA(wdata), .BUS_ACCESS_TYPE(acc), .BUS_RDATA(rdata), .BUS_RDATA_OE(oe),
    .FLASH_SEL(flash), .CARD_LANE_ENABLE_LOW_N(lo_n), .CARD_LANE_ENABLE_HIGH_N(hi_n),
    .CARD_READ(crd), .CARD_ADDR_BUF_OE(a_oe), .CARD_DATA_BUF_OE(d_oe),
    .CARD_DATA_TO_CARD(to_card), .CARD_STATUS_BUF_OE(s_oe), .CARD_LED(led),
    .SERIAL_SHUTDOWN_N(ser_n), .SW_OPTIONS(4'hA));
  // ==========================================================================
  // Tasks
  // One access is one cycle of select; results are read once that edge has landed.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    cs <= 1'b1; wr <= w; addr <= a; wdata <= d;
    @(posedge clk);
    cs <= 1'b0; wdata <= ~d;
    #1;
  endtask : bus
  task automatic flash_try(input logic [2:0] t, input logic e);
    @(posedge clk);
    cs <= 1'b1; wr <= 1'b0; addr <= 32'h0290_0000; acc <= t;
    #1;
    `CHK(flash, e)
    @(posedge clk);
    cs <= 1'b0;
  endtask : flash_try
  task automatic report_and_stop;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // ==========================================================================
  // Clock, watchdog and sequence
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    rstn = 0; cs = 0; wr = 0; addr = 0; wdata = 0; acc = 0; lane_cmd = 2'b11; rd_cmd = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i])
    begin
      bus(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr)
      begin
        `CHK(rdata, rows[i].rd)
        `CHK(oe, rows[i].oe)
      end
    end
    `CHK({a_oe, s_oe, led, ser_n, d_oe}, 5'b11100)
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      lane_cmd <= k ? 2'b01 : 2'b10; rd_cmd <= !k;
      repeat (4) @(posedge clk);
      #1;
      `CHK({d_oe, to_card}, {1'b1, k[0]})
    end
    for (int t = 0; t < 8; t++) flash_try(t[2:0], 1'b1);
    bus(1'b1, 32'h0210_0004, 32'h2000_0000);
    `CHK({a_oe, s_oe, d_oe, led, ser_n}, 5'b00001)
    flash_try(3'h0, 1'b0);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, 32'h0210_0004, 0);
    `CHK({rdata, ser_n, led}, 34'h0)
    report_and_stop();
  end
endmodule : testbench
